// *** bench/clf_top_monitor.sv ***
/*
 * Checker for clf_top: response modes, release and lock compare at the ports.
 * Assumes it is bound to clf_top and shadows configuration writes itself.
 */
`timescale 1ns/100ps
module clf_top_monitor (
   // Clock and reset.
   input wire logic                       clk,
   input wire logic                       rst,
   // Register port.
   input wire logic [clf_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [clf_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                       reg_wr,
   // Drive side.
   input wire logic                       pwm_start,
   input wire logic                       over_limit,
   input wire logic                       recirculate,
   input wire logic                       limit_report,
   input wire logic                       lock_over,
   input wire logic                       fault_indicator_n
);
   import clf_pkg::*;
   logic [DATA_W-1:0] cfg;
   logic [MODE_W-1:0] mode;
   logic [LOCK_W-1:0] lock;
   logic              loud;
   logic              quiet;
   logic              good;
   always_ff @(posedge clk) begin
      if (rst)
         cfg <= '0;
      else if (reg_wr && reg_addr == OFS_CONFIG)
         cfg <= reg_wdata;
   end
   assign mode  = cfg[MODE_LSB +: MODE_W];
   assign lock  = cfg[LOCK_LSB +: LOCK_W];
   assign loud  = mode == 4'h0 || mode == 4'h2 || mode == 4'h4;
   assign quiet = mode == 4'h1 || mode == 4'h3 || mode == 4'h5;
   assign good  = cfg[HSMOD_BIT] || (mode != 4'h2 && mode != 4'h3);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   fault_in_recirc_a: assert property (!fault_indicator_n |-> recirculate)
      else $error("fault indicator low outside recirculation");
   loud_fault_a: assert property ($rose(recirculate) && loud |-> !fault_indicator_n)
      else $error("fault indicator missing in a loud mode");
   quiet_fault_a: assert property (recirculate && quiet |-> fault_indicator_n)
      else $error("fault indicator low in a quiet mode");
   event_recirc_a: assert property (limit_report && mode <= 4'h5 && good |-> recirculate)
      else $error("accepted event without recirculation");
   report_only_a: assert property (mode == 4'h6 && $past(mode) == 4'h6 |-> !recirculate)
      else $error("report mode acted on the drive");
   limit_off_a: assert property (mode >= 4'h7 && $past(mode) >= 4'h7 |->
      !recirculate && !limit_report)
      else $error("disabled limit still acted");
   bad_config_a: assert property (!good && !$past(good) |-> !recirculate)
      else $error("drop mode acted without high-side modulation");
   drop_release_a: assert property (recirculate && (mode == 4'h2 || mode == 4'h3) &&
      !over_limit |-> ##[1:2] !recirculate)
      else $error("no release after sense voltage dropped");
   pwm_release_a: assert property (recirculate && mode <= 4'h1 && pwm_start && !over_limit
      |-> ##[1:2] !recirculate)
      else $error("no release at next PWM cycle");
   lock_zero_a: assert property (lock == 4'h0 && $past(lock) == 4'h0 && $past(lock, 2) == 4'h0
      |-> !lock_over)
      else $error("lock compare fired with zero threshold");
endmodule

// *** bench/test_clf_top.sv ***
/*
 * Self-checking bench for clf_top through its register port and drive pins.
 * Assumes the checker clf_top_monitor is compiled alongside.
 */
`timescale 1ns/100ps
module test_clf_top;
   import clf_pkg::*;
   logic               clk;
   logic               rst;
   logic               reg_wr;
   logic               reg_rd;
   logic               pwm_start;
   logic               over_limit;
   logic               recirculate;
   logic               limit_report;
   logic               lock_over;
   logic               fault_indicator_n;
   logic               irq;
   logic [ADDR_W-1:0]  reg_addr;
   logic [DATA_W-1:0]  reg_wdata;
   logic [DATA_W-1:0]  reg_rdata;
   logic [DATA_W-1:0]  got;
   logic [LEVEL_W-1:0] phase_sense_voltage;
   int                 miscompares = 0;
   int                 checks_done = 0;
   int                 cycles = 0;
   clf_top i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_start,
      .over_limit, .phase_sense_voltage, .recirculate, .limit_report, .lock_over,
      .fault_indicator_n, .irq);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic end_sim();
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic chk(input string name, input logic [DATA_W-1:0] exp,
      input logic [DATA_W-1:0] seen);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      got = reg_rdata;
   endtask
   task automatic pulse();
      @(posedge clk);
      pwm_start <= 1'b1;
      @(posedge clk);
      pwm_start <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      pwm_start = 1'b0;
      over_limit = 1'b0;
      phase_sense_voltage = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_CONFIG);
      chk("config reset", 32'h0, got);
      rd(OFS_STATE);
      chk("state reset", 32'h1, got);
      rd(4'h2);
      chk("unmapped read", 32'h0, got);
      wr(OFS_MASK, 32'h1);
      for (int m = 0; m < 16; m++) begin
         wr(OFS_CONFIG, (32'(m) << MODE_LSB) | 32'h1);
         @(posedge clk);
         over_limit <= 1'b1;
         @(posedge clk);
         if (m != 2 && m != 3) over_limit <= 1'b0;
         #1;
         chk("limit report", 32'(m < 7), limit_report);
         tick(2);
         chk("recirculate", 32'(m < 6), recirculate);
         chk("fault", 32'(!(m == 0 || m == 2 || m == 4)), fault_indicator_n);
         rd(OFS_STATUS);
         chk("limit event", 32'(m < 7), got[IRQ_LIMIT_BIT]);
         chk("irq", 32'(m < 7), irq);
         wr(OFS_STATUS, 32'h1);
         over_limit <= 1'b0;
         pulse();
         tick(2);
         chk("released", 32'h0, recirculate);
         chk("irq cleared", 32'h0, irq);
      end
      wr(OFS_MASK, 32'h4);
      wr(OFS_CONFIG, 32'(MODE_DROP_FLT) << MODE_LSB);
      @(posedge clk);
      over_limit <= 1'b1;
      tick(3);
      chk("bad config recirculate", 32'h0, recirculate);
      chk("bad config irq", 32'h1, irq);
      @(posedge clk);
      over_limit <= 1'b0;
      for (int r = 2; r <= 7; r += 5) begin
         wr(OFS_CONFIG, (32'(MODE_RTRY_FLT) << MODE_LSB) | (32'(r) << RETRY_LSB));
         @(posedge clk);
         over_limit <= 1'b1;
         @(posedge clk);
         over_limit <= 1'b0;
         repeat (r) pulse();
         tick(2);
         chk("retry hold", 32'h1, recirculate);
         pulse();
         tick(2);
         chk("retry end", 32'h0, recirculate);
      end
      for (int c = 0; c < 16; c += 5) begin
         wr(OFS_CONFIG, 32'(c) << LOCK_LSB);
         phase_sense_voltage <= LEVEL_W'(c * LOCK_STEP_MV);
         tick(4);
         chk("lock at level", 32'h0, lock_over);
         @(posedge clk);
         phase_sense_voltage <= LEVEL_W'(c * LOCK_STEP_MV + 1);
         tick(4);
         chk("lock above level", 32'(c != 0), lock_over);
      end
      end_sim();
   end
endmodule
bind clf_top clf_top_monitor i_mon (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .pwm_start,
   .over_limit, .recirculate, .limit_report, .lock_over, .fault_indicator_n);

// *** rtl/clf_lock_cmp.sv ***
/*
 * Lock-detection current comparison: converts the threshold code to a
 * sense level in millivolts and compares it with the sensed level.
 * Assumes the sense level arrives synchronous to clk, in millivolts.
 */
`timescale 1ns/100ps
module clf_lock_cmp (
   // Clock and reset.
   input  wire logic                         clk,
   input  wire logic                         rst,
   // Threshold and sense level.
   input  wire logic [clf_pkg::LOCK_W-1:0]   lock_code,
   input  wire logic [clf_pkg::LEVEL_W-1:0]  sense_mv,
   // Result.
   output logic                              lock_over
);
   import clf_pkg::*;

   logic [LEVEL_W-1:0] thresh_mv;
   logic               next_lock_over;

   always_comb begin
      thresh_mv      = LEVEL_W'(lock_code * LOCK_STEP_MV);  // [R8]
      next_lock_over = (lock_code != 4'h0) && (sense_mv > thresh_mv);  // [R9]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lock_over <= 1'b0;
      end else begin
         lock_over <= next_lock_over;
      end
   end

endmodule

// *** rtl/clf_retry_cnt.sv ***
/*
 * Counter of PWM cycles waited before a retry.
 * Assumes pwm_start is a one-cycle pulse at each PWM period start.
 */
`timescale 1ns/100ps
module clf_retry_cnt #(
   parameter int unsigned WIDTH = clf_pkg::RETRY_W
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst,
   // Control.
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] count,
   input  wire logic             pwm_start,
   // Status.
   output logic                  expired
);
   logic [WIDTH-1:0] remain;
   logic [WIDTH-1:0] next_remain;

   always_comb begin
      next_remain = remain;
      if (load) begin
         next_remain = count;
      end else if (pwm_start && remain != '0) begin
         next_remain = remain - WIDTH'(1);  // [R10]
      end
   end

   assign expired = (remain == '0);

   always_ff @(posedge clk) begin
      if (rst) begin
         remain <= '0;
      end else begin
         remain <= next_remain;
      end
   end

endmodule

// *** rtl/clf_top.sv ***
/*
 * Cycle-by-cycle current limit response logic with lock-detection
 * threshold compare, register port and interrupt.
 * Assumes all inputs synchronous to clk; pwm_start pulses once per PWM
 * period; over_limit is the comparator of phase sense voltage vs limit.
 * Register map: 0x0 configuration, 0x4 status (write one to clear),
 * 0x8 interrupt mask, 0xc response state (read only).
 */
// Operation
// R1 - Mode at bits 26-23; code 0 recirculates, resumes next PWM, asserts fault.
// R2 - Code 1 recirculates and resumes next PWM cycle without fault.
// R3 - Codes 2/3 resume when sense voltage drops; fault only for code 2.
// R4 - Codes 2/3 valid only with high-side modulation.
// R5 - Codes 4/5 resume after retry count PWM cycles; fault only for 4.
// R6 - Code 6 only reports overcurrent, no drive action.
// R7 - Codes 7 to 15 disable the limit; field resets to zero.
// R8 - Lock threshold at bits 22-19, code n means n times 0.1 V.
// R9 - Lock threshold code zero never triggers lock comparison.
// R10 - Retry count at bits 10-8 gives zero to seven PWM cycles.
`timescale 1ns/100ps
module clf_top (
   // Clock and reset.
   input  wire logic                         clk,
   input  wire logic                         rst,
   // Register port.
   input  wire logic [clf_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [clf_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [clf_pkg::DATA_W-1:0]   reg_rdata,
   // Drive side.
   input  wire logic                         pwm_start,
   input  wire logic                         over_limit,
   input  wire logic [clf_pkg::LEVEL_W-1:0]  phase_sense_voltage,
   output logic                              recirculate,
   output logic                              limit_report,
   output logic                              lock_over,
   output logic                              fault_indicator_n,
   // Interrupt.
   output logic                              irq
);
   import clf_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   logic [MODE_W-1:0]  cycle_limit_response_mode;
   logic [LOCK_W-1:0]  lock_code;
   logic [RETRY_W-1:0] cycle_limit_retry_count;
   logic               high_side_mod;
   logic [IRQ_W-1:0]   irq_status;
   logic [IRQ_W-1:0]   irq_mask;
   logic [MODE_W-1:0]  next_mode;
   logic [LOCK_W-1:0]  next_lock_code;
   logic [RETRY_W-1:0] next_retry;
   logic               next_high_side_mod;
   logic [IRQ_W-1:0]   next_irq_status;
   logic [IRQ_W-1:0]   next_irq_mask;
   logic [DATA_W-1:0]  next_rdata;
   logic               next_irq;

   logic               wr_cfg;
   logic               cfg_bad;
   logic               lock_raw;
   logic               lock_prev;
   logic               limit_event;
   logic               retry_load;
   logic               retry_done;
   logic               drop_mode;
   logic               loud_mode;
   logic               wr_mask;
   logic               wr_status;

   clf_state_type      state;
   clf_state_type      next_state;
   logic               next_recirculate;
   logic               next_report;
   logic               next_fault_n;

   assign wr_cfg    = reg_wr && (reg_addr == OFS_CONFIG);
   assign wr_mask   = reg_wr && (reg_addr == OFS_MASK);
   assign wr_status = reg_wr && (reg_addr == OFS_STATUS);

   // Codes 2 and 3 release on the sense voltage; codes 0, 2 and 4 drive the fault pin.
   assign drop_mode = (cycle_limit_response_mode == MODE_DROP_FLT) ||
                      (cycle_limit_response_mode == MODE_DROP_QUIET);
   assign loud_mode = (cycle_limit_response_mode == MODE_NEXT_FLT) ||
                      (cycle_limit_response_mode == MODE_DROP_FLT) ||
                      (cycle_limit_response_mode == MODE_RTRY_FLT);

   // A drop mode without high-side modulation is refused: no drive action, flag only.
   assign cfg_bad = drop_mode && !high_side_mod;  // [R4]

   // A configuration write replaces every field at once; the new mode takes effect at
   // the next edge, also while a response is in progress.
   always_comb begin
      next_mode          = cycle_limit_response_mode;
      next_lock_code     = lock_code;
      next_retry         = cycle_limit_retry_count;
      next_high_side_mod = high_side_mod;
      next_irq_mask      = irq_mask;
      if (wr_cfg) begin
         next_mode          = reg_wdata[MODE_LSB +: MODE_W];  // [R1]
         next_lock_code     = reg_wdata[LOCK_LSB +: LOCK_W];  // [R8]
         next_retry         = reg_wdata[RETRY_LSB +: RETRY_W];  // [R10]
         next_high_side_mod = reg_wdata[HSMOD_BIT];
      end
      if (wr_mask) begin
         next_irq_mask = reg_wdata[IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lock compare and retry counter.

   // The comparator registers its result and the output stage registers it again, so
   // lock_over trails the sense level by two cycles.
   clf_lock_cmp u_lock (
      .clk       (clk),
      .rst       (rst),
      .lock_code (lock_code),
      .sense_mv  (phase_sense_voltage),
      .lock_over (lock_raw)
   );

   // The counter loads the retry count at the event and steps at each PWM period start,
   // so the response ends at the period start after the count has run out.
   clf_retry_cnt #(
      .WIDTH (RETRY_W)
   ) u_retry (
      .clk       (clk),
      .rst       (rst),
      .load      (retry_load),
      .count     (cycle_limit_retry_count),
      .pwm_start (pwm_start),
      .expired   (retry_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Response state machine.
   // One response at a time: an event is taken only in the run state, and a new
   // event can follow one cycle after the return to run.

   always_comb begin
      next_state       = state;
      next_recirculate = 1'b0;
      next_report      = 1'b0;
      next_fault_n     = 1'b1;
      retry_load       = 1'b0;
      limit_event      = 1'b0;
      unique case (state)
         CLF_RUN: begin
            if (over_limit && !cfg_bad && cycle_limit_response_mode <= MODE_REPORT) begin
               limit_event = 1'b1;
               unique case (cycle_limit_response_mode)
                  MODE_RTRY_FLT, MODE_RTRY_QUIET: begin
                     next_state = CLF_RETRY;  // [R5]
                     retry_load = 1'b1;
                  end
                  MODE_REPORT: begin
                     next_state = CLF_RUN;  // [R6]
                  end
                  default: begin
                     next_state = CLF_RECIRC;  // [R1] [R2] [R3]
                  end
               endcase
            end
         end
         CLF_RECIRC: begin
            if (drop_mode) begin
               if (!over_limit) begin
                  next_state = CLF_RUN;  // [R3]
               end
            end else if (pwm_start) begin
               next_state = CLF_RUN;  // [R1] [R2]
            end
         end
         CLF_RETRY: begin
            if (pwm_start && retry_done) begin
               next_state = CLF_RUN;  // [R5] [R10]
            end
         end
      endcase
      // Report-only and disabled modes, or a refused drop mode, hold the run state on
      // every cycle, so switching to one of them also ends a response in progress.
      if (cycle_limit_response_mode >= MODE_REPORT || cfg_bad) begin
         next_state = CLF_RUN;  // [R6] [R7]
      end
      next_recirculate = (next_state != CLF_RUN);
      next_report      = limit_event;
      // The fault indicator follows the response and is low only in the loud codes.
      if (next_state != CLF_RUN) begin
         next_fault_n = !loud_mode;  // [R1] [R2] [R3] [R5]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: hardware set wins over write-one-to-clear.
   // The configuration flag is set on every cycle the refused pairing stands, so a
   // clear only sticks once software has fixed the configuration.

   always_comb begin
      next_irq_status = irq_status;
      if (wr_status) begin
         next_irq_status = irq_status & ~reg_wdata[IRQ_W-1:0];
      end
      if (limit_event) begin
         next_irq_status[IRQ_LIMIT_BIT] = 1'b1;
      end
      if (lock_raw && !lock_prev) begin
         next_irq_status[IRQ_LOCK_BIT] = 1'b1;  // [R9]
      end
      if (cfg_bad) begin
         next_irq_status[IRQ_CFG_BIT] = 1'b1;  // [R4]
      end
      next_irq = |(next_irq_status & next_irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data.
   // Read data are zero outside the cycle after a read strobe, so an idle port
   // always reads as zero and no stale word lingers on the bus.

   always_comb begin
      next_rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CONFIG: begin
               next_rdata[MODE_LSB +: MODE_W]   = cycle_limit_response_mode;
               next_rdata[LOCK_LSB +: LOCK_W]   = lock_code;
               next_rdata[RETRY_LSB +: RETRY_W] = cycle_limit_retry_count;
               next_rdata[HSMOD_BIT]            = high_side_mod;
            end
            OFS_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
            OFS_MASK:   next_rdata[IRQ_W-1:0] = irq_mask;
            OFS_STATE:  next_rdata[2:0]       = state;
            default:    next_rdata            = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers, one block per group of state.

   always_ff @(posedge clk) begin
      if (rst) begin
         cycle_limit_response_mode <= MODE_RESET;  // [R7]
         lock_code                 <= LOCK_RESET;
         cycle_limit_retry_count   <= RETRY_RESET;
         high_side_mod             <= 1'b0;
         irq_mask                  <= '0;
      end else begin
         cycle_limit_response_mode <= next_mode;
         lock_code                 <= next_lock_code;
         cycle_limit_retry_count   <= next_retry;
         high_side_mod             <= next_high_side_mod;
         irq_mask                  <= next_irq_mask;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lock_over <= 1'b0;
         lock_prev <= 1'b0;
      end else begin
         lock_over <= lock_raw;
         lock_prev <= lock_raw;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state             <= CLF_RUN;
         recirculate       <= 1'b0;
         limit_report      <= 1'b0;
         fault_indicator_n <= 1'b1;
      end else begin
         state             <= next_state;
         recirculate       <= next_recirculate;
         limit_report      <= next_report;
         fault_indicator_n <= next_fault_n;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= '0;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq        <= next_irq;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule

// *** shared/clf_pkg.sv ***
/*
 * Package for the cycle-by-cycle current limit response block: register
 * offsets, field positions, reset values, mode codes and widths.
 * Assumes a single 250 MHz clock domain and a plain register port.
 */
package clf_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;

   // Register offsets (byte addresses, word aligned).
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STATE  = 4'hc;

   // Configuration word field positions.
   localparam int unsigned MODE_LSB  = 23;
   localparam int unsigned MODE_W    = 4;
   localparam int unsigned LOCK_LSB  = 19;
   localparam int unsigned LOCK_W    = 4;
   localparam int unsigned RETRY_LSB = 8;
   localparam int unsigned RETRY_W   = 3;
   localparam int unsigned HSMOD_BIT = 0;

   // Reset values.
   localparam logic [MODE_W-1:0]  MODE_RESET  = 4'h0;
   localparam logic [LOCK_W-1:0]  LOCK_RESET  = 4'h0;
   localparam logic [RETRY_W-1:0] RETRY_RESET = 3'h0;

   // Response mode codes; every code from 7 upward disables the limit.
   localparam logic [MODE_W-1:0] MODE_NEXT_FLT   = 4'h0;
   localparam logic [MODE_W-1:0] MODE_NEXT_QUIET = 4'h1;
   localparam logic [MODE_W-1:0] MODE_DROP_FLT   = 4'h2;
   localparam logic [MODE_W-1:0] MODE_DROP_QUIET = 4'h3;
   localparam logic [MODE_W-1:0] MODE_RTRY_FLT   = 4'h4;
   localparam logic [MODE_W-1:0] MODE_RTRY_QUIET = 4'h5;
   localparam logic [MODE_W-1:0] MODE_REPORT     = 4'h6;

   // Threshold code step in millivolts; code n means n * step.
   localparam int unsigned LOCK_STEP_MV = 100;
   localparam int unsigned LEVEL_W      = 12;

   // Interrupt status bits.
   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned IRQ_LIMIT_BIT = 0;
   localparam int unsigned IRQ_LOCK_BIT  = 1;
   localparam int unsigned IRQ_CFG_BIT   = 2;

   typedef enum logic [2:0] {
      CLF_RUN     = 3'b001,
      CLF_RECIRC  = 3'b010,
      CLF_RETRY   = 3'b100
   } clf_state_type;

endpackage
